// >>> logic/eic_pkg.sv
// constants for the external interrupt configuration block
// assumes an 8-bit register port and an 8-pin port 0
package eic_pkg;

	// --------------------------------------------------------------
	// widths
	// --------------------------------------------------------------
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 8;
	localparam int SEL_W     = 3;
	localparam int PIN_COUNT = 8;
	localparam int STAT_W    = 2;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_PIN_CFG   = 8'hE4;
	localparam logic [7:0] ADDR_TIMER_CTL = 8'hE0;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'hE1;
	localparam logic [7:0] ADDR_IRQ_PRIO  = 8'hE2;
	localparam logic [7:0] ADDR_EVT_STAT  = 8'hE8;
	localparam logic [7:0] ADDR_EVT_MASK  = 8'hE9;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_PIN_CFG   = 8'h01;
	localparam logic [7:0] RST_TIMER_CTL = 8'h00;
	localparam logic [7:0] RST_IRQ_EN    = 8'h00;
	localparam logic [7:0] RST_IRQ_PRIO  = 8'h00;
	localparam logic [1:0] RST_EVT_MASK  = 2'h0;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int CFG_SEL_A_LSB   = 0;
	localparam int CFG_POL_A_BIT   = 3;
	localparam int CFG_SEL_B_LSB   = 4;
	localparam int CFG_POL_B_BIT   = 7;
	localparam int TCTL_EDGE_A_BIT = 0;
	localparam int TCTL_PEND_A_BIT = 1;
	localparam int TCTL_EDGE_B_BIT = 2;
	localparam int TCTL_PEND_B_BIT = 3;
	localparam int IEN_MASK_A_BIT  = 0;
	localparam int IEN_MASK_B_BIT  = 2;
	localparam int IEN_GLOBAL_BIT  = 7;
	localparam int PRIO_A_BIT      = 0;
	localparam int PRIO_B_BIT      = 2;
	localparam int PRIO_FIXED_BIT  = 7;
	localparam int STAT_A_BIT      = 0;
	localparam int STAT_B_BIT      = 1;

endpackage

// >>> logic/eic_channel.sv
// one external interrupt input: pin select, polarity, edge/level sense
// assumes pin_sync is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none

module eic_channel
	import eic_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [PIN_COUNT-1:0] pin_sync,
	input  wire logic [SEL_W-1:0]     pin_sel,
	input  wire logic                 polarity,
	input  wire logic                 edge_sel,
	input  wire logic                 vec_ack,
	input  wire logic                 pend_wr,
	input  wire logic                 pend_wdata,
	output logic                      pending,
	output logic                      rise
);

	// --------------------------------------------------------------
	// sensing
	// --------------------------------------------------------------
	logic active;
	logic active_d;
	logic next_pending;
	logic pend_clr;
	logic pend_set;

	// polarity 0 means active low
	assign active = pin_sync[pin_sel] ~^ polarity; // R1 R3
	assign rise   = active & ~active_d;
	assign pend_set = rise | (pend_wr & pend_wdata);
	assign pend_clr = vec_ack | (pend_wr & ~pend_wdata);

	// edge mode: set wins over clear; level mode follows the pin
	assign next_pending = edge_sel ? (pend_set | (pending & ~pend_clr)) // R8
	                               : active; // R9 R2

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_d <= 1'b0;
			pending  <= 1'b0;
		end else begin
			active_d <= active;
			pending  <= next_pending;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_LEVEL_FOLLOW: assert property (@(posedge clk) disable iff (rst) // R9
		!edge_sel |=> pending
		              == ($past(pin_sync[pin_sel]) == $past(polarity)))
		else $error("level pending does not follow pin");

	AST_EDGE_SET: assert property (@(posedge clk) disable iff (rst) // R8
		(edge_sel && rise) |=> pending)
		else $error("active edge did not set pending");

	AST_VEC_CLEAR: assert property (@(posedge clk) disable iff (rst) // R8
		(edge_sel && vec_ack && !rise && !(pend_wr && pend_wdata))
		|=> !pending)
		else $error("vectoring did not clear pending");

	AST_POLARITY: assert property (@(posedge clk) disable iff (rst) // R1
		rise |-> (pin_sync[pin_sel] == polarity
		          && $past(pin_sync[pin_sel]) != polarity
		          || $past(pin_sel) != pin_sel
		          || $past(polarity) != polarity))
		else $error("edge seen at wrong pin level");

endmodule

`default_nettype wire

// >>> logic/eic_top.sv
// external interrupt configuration block, top level
// holds pin routing, polarity, sense mode, pending flags and masks
// assumes a one-cycle register port on REF_CLK and raw port 0 pins
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: polarity bit 0 active low, 1 high
// R2: trigger bit 1 edge, 0 level sensing
// R3: three-bit select picks port 0 pin
// R4: config byte: pol b, sel b, pol a, sel a
// R5: pins only observed, never driven
// R6: software skips, open-drains, latches interrupt pins
// R7: pending flags at timer control bits 1, 3
// R8: edge sets pending, vectoring clears it
// R9: level pending follows active pin level
// R10: source holds request until recognised
// R11: source drops request before routine ends
// R12: per-input mask bits 0 and 2 gate requests
// R13: global enable bit 7 blocks all requests; IRQ output is not gated by it
// R14: priority bits 0 and 2, high when 1
// R15: pins pass two-flop synchroniser first
module eic_top
	import eic_pkg::*;
#(
	parameter int PINS = PIN_COUNT
)
(
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WR_DATA,
	input  wire logic              WR_EN,
	input  wire logic              RD_EN,
	output logic      [DATA_W-1:0] RD_DATA,
	input  wire logic [PINS-1:0]   P0_IN,
	input  wire logic              VEC_ACK_A,
	input  wire logic              VEC_ACK_B,
	output logic                   IRQ_REQ_A,
	output logic                   IRQ_REQ_B,
	output logic                   IRQ_PRIO_A,
	output logic                   IRQ_PRIO_B,
	output logic                   IRQ
);

	// --------------------------------------------------------------
	// parameter check
	// --------------------------------------------------------------
	if (PINS != PIN_COUNT) begin : g_bad_pins
		$error("pin count must match the select width");
	end

	// --------------------------------------------------------------
	// decode helper
	// --------------------------------------------------------------
	function automatic logic hit(input logic              en,
	                             input logic [ADDR_W-1:0] a,
	                             input logic [ADDR_W-1:0] target);
		hit = en && (a == target);
	endfunction

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic [PINS-1:0]   p0_meta;
	logic [PINS-1:0]   p0_sync;
	logic [DATA_W-1:0] pin_cfg;
	logic [DATA_W-1:0] irq_en;
	logic [DATA_W-1:0] irq_prio;
	logic              irq_a_edge_sel;
	logic              irq_b_edge_sel;
	logic [STAT_W-1:0] evt_stat;
	logic [STAT_W-1:0] evt_mask;
	logic              irq_a_pending;
	logic              irq_b_pending;
	logic              rise_a;
	logic              rise_b;

	wire logic wr_cfg  = hit(WR_EN, ADDR, ADDR_PIN_CFG);
	wire logic wr_tctl = hit(WR_EN, ADDR, ADDR_TIMER_CTL);
	wire logic wr_ien  = hit(WR_EN, ADDR, ADDR_IRQ_EN);
	wire logic wr_prio = hit(WR_EN, ADDR, ADDR_IRQ_PRIO);
	wire logic wr_mask = hit(WR_EN, ADDR, ADDR_EVT_MASK);
	wire logic rd_stat = hit(RD_EN, ADDR, ADDR_EVT_STAT);

	// --------------------------------------------------------------
	// pin synchroniser
	// --------------------------------------------------------------
	// pins are inputs only, so a crossbar peripheral is never disturbed
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			// idle pull-up level, so no false edge follows reset
			p0_meta <= '1;
			p0_sync <= '1;
		end else begin
			p0_meta <= P0_IN; // R15 R5
			p0_sync <= p0_meta;
		end
	end

	// --------------------------------------------------------------
	// configuration fields
	// --------------------------------------------------------------
	wire logic [SEL_W-1:0] irq_a_pin_sel  = pin_cfg[CFG_SEL_A_LSB +: SEL_W];
	wire logic [SEL_W-1:0] irq_b_pin_sel  = pin_cfg[CFG_SEL_B_LSB +: SEL_W];
	wire logic             irq_a_polarity = pin_cfg[CFG_POL_A_BIT]; // R4
	wire logic             irq_b_polarity = pin_cfg[CFG_POL_B_BIT];
	wire logic             irq_a_mask     = irq_en[IEN_MASK_A_BIT];
	wire logic             irq_b_mask     = irq_en[IEN_MASK_B_BIT];
	wire logic             global_irq_en  = irq_en[IEN_GLOBAL_BIT];
	wire logic             irq_a_priority = irq_prio[PRIO_A_BIT];
	wire logic             irq_b_priority = irq_prio[PRIO_B_BIT];

	// pending writes only matter in edge mode
	wire logic pend_a_wdata = WR_DATA[TCTL_PEND_A_BIT];
	wire logic pend_b_wdata = WR_DATA[TCTL_PEND_B_BIT];

	// --------------------------------------------------------------
	// configuration registers
	// --------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pin_cfg        <= RST_PIN_CFG;
			irq_a_edge_sel <= RST_TIMER_CTL[TCTL_EDGE_A_BIT];
			irq_b_edge_sel <= RST_TIMER_CTL[TCTL_EDGE_B_BIT];
			irq_en         <= RST_IRQ_EN;
			irq_prio       <= RST_IRQ_PRIO;
			evt_mask       <= RST_EVT_MASK;
		end else begin
			if (wr_cfg) begin
				pin_cfg <= WR_DATA; // R4 R3
			end
			if (wr_tctl) begin
				irq_a_edge_sel <= WR_DATA[TCTL_EDGE_A_BIT]; // R2
				irq_b_edge_sel <= WR_DATA[TCTL_EDGE_B_BIT];
			end
			if (wr_ien) begin
				irq_en <= WR_DATA;
			end
			if (wr_prio) begin
				irq_prio <= WR_DATA;
			end
			if (wr_mask) begin
				evt_mask <= WR_DATA[STAT_W-1:0];
			end
		end
	end

	// --------------------------------------------------------------
	// input channels
	// --------------------------------------------------------------
	eic_channel u_chan_a (
		.clk        (REF_CLK),
		.rst        (RST),
		.pin_sync   (p0_sync),
		.pin_sel    (irq_a_pin_sel),
		.polarity   (irq_a_polarity),
		.edge_sel   (irq_a_edge_sel),
		.vec_ack    (VEC_ACK_A),
		.pend_wr    (wr_tctl),
		.pend_wdata (pend_a_wdata),
		.pending    (irq_a_pending),
		.rise       (rise_a)
	);

	eic_channel u_chan_b (
		.clk        (REF_CLK),
		.rst        (RST),
		.pin_sync   (p0_sync),
		.pin_sel    (irq_b_pin_sel),
		.polarity   (irq_b_polarity),
		.edge_sel   (irq_b_edge_sel),
		.vec_ack    (VEC_ACK_B),
		.pend_wr    (wr_tctl),
		.pend_wdata (pend_b_wdata),
		.pending    (irq_b_pending),
		.rise       (rise_b)
	);

	// --------------------------------------------------------------
	// processor requests
	// --------------------------------------------------------------
	wire logic next_req_a = global_irq_en & irq_a_mask & irq_a_pending;
	wire logic next_req_b = global_irq_en & irq_b_mask & irq_b_pending;

	// --------------------------------------------------------------
	// event status, cleared by reading it
	// --------------------------------------------------------------
	logic [STAT_W-1:0] evt_set;
	logic [STAT_W-1:0] next_evt_stat;

	assign evt_set[STAT_A_BIT] = rise_a;
	assign evt_set[STAT_B_BIT] = rise_b;
	// set wins over the read clear
	assign next_evt_stat = (rd_stat ? '0 : evt_stat) | evt_set;

	wire logic next_irq = |(next_evt_stat & evt_mask);

	// --------------------------------------------------------------
	// read mux
	// --------------------------------------------------------------
	logic [DATA_W-1:0] tctl_view;
	logic [DATA_W-1:0] ien_view;
	logic [DATA_W-1:0] prio_view;
	logic [DATA_W-1:0] next_rd_data;

	always_comb begin
		tctl_view                  = '0;
		tctl_view[TCTL_EDGE_A_BIT] = irq_a_edge_sel;
		tctl_view[TCTL_PEND_A_BIT] = irq_a_pending; // R7
		tctl_view[TCTL_EDGE_B_BIT] = irq_b_edge_sel;
		tctl_view[TCTL_PEND_B_BIT] = irq_b_pending; // R7
		ien_view                   = '0;
		ien_view[IEN_MASK_A_BIT]   = irq_a_mask;
		ien_view[IEN_MASK_B_BIT]   = irq_b_mask;
		ien_view[IEN_GLOBAL_BIT]   = global_irq_en;
		prio_view                  = '0;
		prio_view[PRIO_A_BIT]      = irq_a_priority;
		prio_view[PRIO_B_BIT]      = irq_b_priority;
		prio_view[PRIO_FIXED_BIT]  = 1'b1;
	end

	always_comb begin
		next_rd_data = '0;
		if (RD_EN) begin
			case (ADDR)
				ADDR_PIN_CFG:   next_rd_data = pin_cfg;
				ADDR_TIMER_CTL: next_rd_data = tctl_view;
				ADDR_IRQ_EN:    next_rd_data = ien_view;
				ADDR_IRQ_PRIO:  next_rd_data = prio_view;
				ADDR_EVT_STAT:  next_rd_data = {{(DATA_W-STAT_W){1'b0}}, evt_stat};
				ADDR_EVT_MASK:  next_rd_data = {{(DATA_W-STAT_W){1'b0}}, evt_mask};
				default:        next_rd_data = '0;
			endcase
		end
	end

	// --------------------------------------------------------------
	// output registers
	// --------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RD_DATA    <= '0;
			IRQ_REQ_A  <= 1'b0;
			IRQ_REQ_B  <= 1'b0;
			IRQ_PRIO_A <= 1'b0;
			IRQ_PRIO_B <= 1'b0;
			evt_stat   <= '0;
			IRQ        <= 1'b0;
		end else begin
			RD_DATA    <= next_rd_data;
			IRQ_REQ_A  <= next_req_a; // R12 R13
			IRQ_REQ_B  <= next_req_b; // R12 R13
			IRQ_PRIO_A <= irq_a_priority; // R14
			IRQ_PRIO_B <= irq_b_priority; // R14
			evt_stat   <= next_evt_stat;
			IRQ        <= next_irq;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_SYNC_DELAY: assert property (@(posedge REF_CLK) disable iff (RST) // R15
		(!$past(RST) && !$past(RST, 2)) |-> p0_sync == $past(P0_IN, 2))
		else $error("pin synchroniser latency is not two cycles");

	AST_MASK_BLOCK: assert property (@(posedge REF_CLK) disable iff (RST) // R12
		!irq_a_mask |=> !IRQ_REQ_A)
		else $error("masked input a still requests");

	AST_REQ_B: assert property (@(posedge REF_CLK) disable iff (RST) // R12
		(global_irq_en && irq_b_mask && irq_b_pending) |=> IRQ_REQ_B)
		else $error("enabled pending input b did not request");

	AST_GLOBAL_OFF: assert property (@(posedge REF_CLK) disable iff (RST) // R13
		!global_irq_en |=> !(IRQ_REQ_A || IRQ_REQ_B))
		else $error("request passed with global enable off");

	AST_PRIO_A: assert property (@(posedge REF_CLK) disable iff (RST) // R14
		wr_prio |=> ##1 IRQ_PRIO_A == $past(WR_DATA[PRIO_A_BIT], 2))
		else $error("priority a does not follow its register");

	AST_CFG_WRITE: assert property (@(posedge REF_CLK) disable iff (RST) // R4
		wr_cfg |=> (irq_b_polarity == $past(WR_DATA[CFG_POL_B_BIT])
		            && irq_a_pin_sel == $past(WR_DATA[2:0])))
		else $error("config fields not at their bit positions");

	AST_TCTL_READ: assert property (@(posedge REF_CLK) disable iff (RST) // R7
		hit(RD_EN, ADDR, ADDR_TIMER_CTL)
		|=> RD_DATA[TCTL_PEND_B_BIT] == $past(irq_b_pending))
		else $error("pending b not at its timer control bit");

	AST_STAT_CLEAR: assert property (@(posedge REF_CLK) disable iff (RST)
		(rd_stat && !rise_a && !rise_b) |=> evt_stat == '0)
		else $error("status read did not clear");

	AST_STAT_SET: assert property (@(posedge REF_CLK) disable iff (RST)
		rise_a |=> evt_stat[STAT_A_BIT])
		else $error("edge of input a did not set its status bit");

	AST_PRIO_B: assert property (@(posedge REF_CLK) disable iff (RST) // R14
		wr_prio |=> ##1 IRQ_PRIO_B == $past(WR_DATA[PRIO_B_BIT], 2))
		else $error("priority b does not follow its register");

endmodule

`default_nettype wire

// >>> test/eic_pin_src.sv
// pin source model: open-drain drivers with pull-ups on port 0
// assumes bench commands applied just after rising clk edges
`timescale 1ns/1ps
`default_nettype none

module eic_pin_src (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] pull_low,
	input  wire logic [7:0] req_set,
	input  wire logic       ack,
	output logic      [7:0] pins
);
	logic [7:0] req;

	// level request held until acknowledged, then dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			req <= 8'h00;
		else if (ack)
			req <= 8'h00;
		else
			req <= req | req_set;
	end

	// released pins float up to the pull-up level
	assign pins = ~(pull_low | req);
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the external interrupt block
// assumes the pin source model drives all port 0 pins
`timescale 1ns/1ps
`default_nettype none

module testbench
	import eic_pkg::*;
;
	logic       clk, rst, wr, rd_en, ack_a, ack_b;
	logic       req_a, req_b, pr_a, pr_b, irq;
	logic [7:0] addr, wdata, rdata, pins, pull_low, req_set, d;
	int         n_errors, samples_checked, seed, s, p, k;

	eic_top #(.PINS(8)) dut_u (.REF_CLK(clk), .RST(rst), .ADDR(addr),
		.WR_DATA(wdata), .WR_EN(wr), .RD_EN(rd_en), .RD_DATA(rdata),
		.P0_IN(pins), .VEC_ACK_A(ack_a), .VEC_ACK_B(ack_b),
		.IRQ_REQ_A(req_a), .IRQ_REQ_B(req_b), .IRQ_PRIO_A(pr_a),
		.IRQ_PRIO_B(pr_b), .IRQ(irq));
	eic_pin_src src_u (.clk(clk), .rst(rst), .pull_low(pull_low),
		.req_set(req_set), .ack(ack_a), .pins(pins));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wreg(logic [7:0] a, logic [7:0] dd);
		@(posedge clk);
		addr <= a;
		wdata <= dd;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rchk(string name, logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask

	task automatic rd_clr(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
	endtask

	task automatic vec(logic [1:0] m);
		@(posedge clk);
		{ack_b, ack_a} <= m;
		@(posedge clk);
		{ack_b, ack_a} <= 2'b00;
	endtask

	// level pending of both inputs from pin levels and config
	function automatic logic [7:0] exp_lvl(logic [7:0] pv, logic [7:0] c);
		logic a, b;
		a = pv[c[2:0]] ~^ c[3];
		b = pv[c[6:4]] ~^ c[7];
		return {4'h0, b, 1'b0, a, 1'b0};
	endfunction

	task automatic end_sim();
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h8d05_e5e6;
		rst = 1'b1;
		{wr, rd_en, ack_a, ack_b} = 4'h0;
		{addr, wdata, pull_low, req_set} = 32'h0000_0000;
		cyc(8);
		rst <= 1'b0;
		rchk("cfg_rst", ADDR_PIN_CFG, RST_PIN_CFG);
		cyc(4);
		rchk("tctl_rst", ADDR_TIMER_CTL, 8'h00);
		rchk("ien_rst", ADDR_IRQ_EN, 8'h00);
		rchk("prio_rst", ADDR_IRQ_PRIO, 8'h80);
		rchk("emask_rst", ADDR_EVT_MASK, 8'h00);
		d = 8'($random(seed));
		wreg(ADDR_PIN_CFG, d);
		wreg(8'h55, 8'hff);
		rchk("unmapped", 8'h55, 8'h00);
		rchk("cfg_rw", ADDR_PIN_CFG, d);
		d = 8'($random(seed));
		wreg(ADDR_IRQ_PRIO, d);
		rchk("prio", ADDR_IRQ_PRIO, 8'h80 | (d & 8'h05));
		chk("prio_out", {6'h0, pr_b, pr_a}, {6'h0, d[2], d[0]});
		// every select code and polarity, random pin levels
		for (k = 0; k < 32; k++) begin
			s = k % 8;
			p = (k / 8) % 2;
			d = {~p[0], 3'(7 - s), p[0], s[2:0]};
			wreg(ADDR_PIN_CFG, d);
			pull_low <= 8'($random(seed));
			cyc(4);
			rchk("lvl_pend", ADDR_TIMER_CTL, exp_lvl(pins, d));
		end
		// edge mode: a on pin 0 active high, b on pin 1 active low
		wreg(ADDR_PIN_CFG, 8'h18);
		pull_low <= 8'h01;
		wreg(ADDR_TIMER_CTL, 8'h05);
		cyc(4);
		wreg(ADDR_TIMER_CTL, 8'h05);
		rd_clr(ADDR_EVT_STAT);
		rchk("evt_flush", ADDR_EVT_STAT, 8'h00);
		rchk("edge_idle", ADDR_TIMER_CTL, 8'h05);
		pull_low <= 8'h02;
		cyc(4);
		pull_low <= 8'h01;
		cyc(4);
		rchk("edge_pend", ADDR_TIMER_CTL, 8'h0f);
		chk("irq_masked", {7'h0, irq}, 8'h00);
		wreg(ADDR_EVT_MASK, 8'h03);
		cyc(2);
		chk("irq_on", {7'h0, irq}, 8'h01);
		rchk("evt", ADDR_EVT_STAT, 8'h03);
		cyc(2);
		chk("irq_off", {7'h0, irq}, 8'h00);
		rchk("evt_clr", ADDR_EVT_STAT, 8'h00);
		wreg(ADDR_IRQ_EN, 8'hff);
		rchk("ien", ADDR_IRQ_EN, 8'h85);
		chk("req_on", {6'h0, req_b, req_a}, 8'h03);
		wreg(ADDR_IRQ_EN, 8'h05);
		cyc(2);
		chk("req_glob", {6'h0, req_b, req_a}, 8'h00);
		wreg(ADDR_IRQ_EN, 8'h84);
		cyc(2);
		chk("req_mask", {6'h0, req_b, req_a}, 8'h02);
		wreg(ADDR_IRQ_EN, 8'h85);
		vec(2'b01);
		rchk("vec_a", ADDR_TIMER_CTL, 8'h0d);
		vec(2'b10);
		rchk("vec_b", ADDR_TIMER_CTL, 8'h05);
		wreg(ADDR_TIMER_CTL, 8'h0f);
		rchk("pend_sw_set", ADDR_TIMER_CTL, 8'h0f);
		chk("req_sw", {6'h0, req_b, req_a}, 8'h03);
		wreg(ADDR_TIMER_CTL, 8'h05);
		rchk("pend_sw_clr", ADDR_TIMER_CTL, 8'h05);
		cyc(2);
		chk("req_done", {6'h0, req_b, req_a}, 8'h00);
		// level mode: both inputs on pin 2, active low, held by source
		wreg(ADDR_TIMER_CTL, 8'h00);
		wreg(ADDR_PIN_CFG, 8'h22);
		pull_low <= 8'h00;
		req_set <= 8'h04;
		@(posedge clk);
		req_set <= 8'h00;
		cyc(4);
		rchk("lvl_hold", ADDR_TIMER_CTL, 8'h0a);
		vec(2'b10);
		cyc(2);
		rchk("lvl_ack_b", ADDR_TIMER_CTL, 8'h0a);
		vec(2'b01);
		cyc(4);
		rchk("lvl_drop", ADDR_TIMER_CTL, 8'h00);
		// mid-run reset restores configuration and enables
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		rchk("cfg_rst2", ADDR_PIN_CFG, RST_PIN_CFG);
		rchk("ien_rst2", ADDR_IRQ_EN, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
